/* File: logic/osc_divider.sv */
// Oscillator divider chain with periodic calibration, 512 Hz test
// square wave and a 16 Hz tick. Assumes a 32768 Hz crystal pin.
`timescale 1ns/10ps
module osc_divider
  import rtc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic osc_pin,
  input wire logic halt,
  input wire logic cal_sign,
  input wire logic [4:0] cal_mag,
  output logic sec_tick,
  output logic sq512,
  output logic tick16
);
  logic osc_s;
  logic osc_d;
  logic [10:0] pre;
  logic [7:0] stage1;
  logic [6:0] stage2;
  logic hold_pass;
  logic [5:0] sec_in_min;
  logic [5:0] cal_min;

  pin_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_osc (
    .mclk(mclk),
    .rstn(rstn),
    .din(osc_pin),
    .dout(osc_s)
  );

  // ---------------------------------------------------------------
  // Decode of the chain
  // ---------------------------------------------------------------
  // The stop bit gates the count; the crystal itself keeps running.
  wire osc_tick = osc_s & ~osc_d & ~halt;
  wire mod_now = (sec_in_min == 6'h00) & (cal_min < {cal_mag, 1'b0});
  wire first_pass = (stage2 == 7'h00);
  wire short_wrap = mod_now & cal_sign & first_pass
                    & (stage1 == STAGE_SHORT_WRAP);
  wire s1_wrap = osc_tick & ((stage1 == STAGE_WRAP) | short_wrap);
  wire hold = mod_now & ~cal_sign & first_pass & ~hold_pass;
  wire sec_end = s1_wrap & ~hold & (stage2 == STAGE2_LAST);

  // ---------------------------------------------------------------
  // Uncorrected prescaler for test and watchdog timing
  // ---------------------------------------------------------------
  // Taken ahead of the correction so calibration never moves 512 Hz.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      osc_d <= 1'b0;
      pre <= 11'h000;
      sq512 <= 1'b0;
      tick16 <= 1'b0;
    end else begin
      osc_d <= osc_s;
      pre <= osc_tick ? pre + 11'h001 : pre;
      sq512 <= pre[SQ_BIT];
      tick16 <= osc_tick & (pre == TICK16_LAST);
    end
  end

  // ---------------------------------------------------------------
  // Corrected chain: the divide-by-256 stage takes the correction
  // ---------------------------------------------------------------
  // A short first pass drops 128 counts; a repeated pass adds 256.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 8'h00;
      stage2 <= 7'h00;
      hold_pass <= 1'b0;
      sec_in_min <= 6'h00;
      cal_min <= 6'h00;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= sec_end;
      if (s1_wrap) begin
        stage1 <= 8'h00;
        hold_pass <= hold | (hold_pass & ~sec_end);
        stage2 <= hold ? stage2 : stage2 + 7'h01;
      end else if (osc_tick) begin
        stage1 <= stage1 + 8'h01;
      end
      if (sec_end) begin
        hold_pass <= 1'b0;
        sec_in_min <= (sec_in_min == SEC_LAST) ? 6'h00
                      : sec_in_min + 6'h01;
        // The 64-minute cycle wraps naturally in six bits.
        if (sec_in_min == SEC_LAST) cal_min <= cal_min + 6'h01;
      end
    end
  end

endmodule : osc_divider

/* File: logic/pin_sync.sv */
// Two-stage synchroniser for a group of pins.
// Assumes multi-bit groups are stable while their strobes are active.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  // ---------------------------------------------------------------
  // One pair of flip-flops per bit
  // ---------------------------------------------------------------
  // The first stage feeds only the second, never any logic.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        meta[i] <= RST_VAL[i];
        dout[i] <= RST_VAL[i];
      end else begin
        meta[i] <= din[i];
        dout[i] <= meta[i];
      end
    end
  end

endmodule : pin_sync

/* File: logic/rtc_pkg.sv */
// Shared constants and carrier types for the clock support block.
// Assumes a byte-wide host bus with 17 address bits and a 50 MHz mclk.
package rtc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [16:0] ADDR_FLAGS = 17'h1FFF0;
  localparam logic [16:0] ADDR_AL_SEC = 17'h1FFF2;
  localparam logic [16:0] ADDR_AL_MIN = 17'h1FFF3;
  localparam logic [16:0] ADDR_AL_HOUR = 17'h1FFF4;
  localparam logic [16:0] ADDR_AL_DATE = 17'h1FFF5;
  localparam logic [16:0] ADDR_AL_MONTH = 17'h1FFF6;
  localparam logic [16:0] ADDR_WDOG = 17'h1FFF7;
  localparam logic [16:0] ADDR_CTRL = 17'h1FFF8;
  localparam logic [16:0] ADDR_SEC = 17'h1FFF9;
  localparam logic [16:0] ADDR_DAY = 17'h1FFFC;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int BIT_WDF = 7;
  localparam int BIT_AF = 6;
  localparam int BIT_BL = 4;
  localparam int BIT_AFE = 7;
  localparam int BIT_ABE = 5;
  localparam int BIT_WDS = 7;
  localparam int BIT_ST = 7;
  localparam int BIT_FT = 6;
  localparam int BIT_SIGN = 5;
  localparam int BIT_RPT = 7;
  localparam int BIT_RPT5 = 6;
  localparam int MULT_HI = 6;
  localparam int MULT_LO = 2;
  localparam int CAL_HI = 4;
  localparam int SEC_W = 7;
  localparam int HOUR_W = 6;
  localparam int DATE_W = 6;
  localparam int MONTH_W = 5;

  // ---------------------------------------------------------------
  // Repeat codes, ordered RPT5 down to RPT1
  // ---------------------------------------------------------------
  localparam logic [4:0] RPT_EVERY_SEC = 5'h1F;
  localparam logic [4:0] RPT_MINUTE = 5'h1E;
  localparam logic [4:0] RPT_HOUR = 5'h1C;
  localparam logic [4:0] RPT_DAY = 5'h18;
  localparam logic [4:0] RPT_MONTH = 5'h10;
  localparam logic [4:0] RPT_YEAR = 5'h00;

  // ---------------------------------------------------------------
  // Divider chain and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] STAGE_WRAP = 8'hFF;
  localparam logic [7:0] STAGE_SHORT_WRAP = 8'h7F;
  localparam logic [6:0] STAGE2_LAST = 7'h7F;
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [10:0] TICK16_LAST = 11'h7FF;
  localparam int SQ_BIT = 5;
  localparam int CLK_HZ = 50_000_000;
  localparam int RST_PULSE_MS = 40;
  localparam int RST_PULSE_CYC = RST_PULSE_MS * (CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
  } time_now_s;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic kick;
    logic [16:0] addr;
    logic [7:0] data;
  } bus_pins_s;

endpackage : rtc_pkg

/* File: logic/rtc_support.sv */
// Clock support top: host registers, calibration, alarm, watchdog and
// the open-drain interrupt/test and reset outputs.
// Assumes the time counters outside advance on sec_tick and present
// their BCD values on time_now; the host bus pins are asynchronous.
//
// How it works
// - Calibration adds or drops counts at the divide-by-256 stage only.
// - Calibration magnitude is five unsigned bits D4-D0 of control.
// - Control bit D5 one speeds the clock, zero slows it.
// - 64-minute cycle; one second per minute shortened 128 or lengthened 256.
// - Value N corrects only the first 2N minutes of each cycle.
// - Test pin toggles 512 Hz under stop, test, enable and steer conditions.
// - Test frequency comes from before the correction.
// - Alarm match sets the alarm flag, and the pin if enabled.
// - Repeat bits pick second to yearly; unknown codes mean every second.
// - Flags read releases alarm pin; cleared flag shows on a later read.
// - On battery the alarm drives the pin only with both enables set.
// - Power-up clears both alarm enables; alarm then only sets the flag.
// - Watchdog timeout equals multiplier times selected resolution.
// - Timeout sets watchdog flag; reading flags clears it.
// - Timeout drives the pin, or a 40-200 ms reset pulse when steered.
// - Steered timeout clears the watchdog register and the test bit.
// - Kick pin edges and watchdog writes restart the count.
// - Writing 00h after interrupt timeout releases pin and disables watchdog.
// - Power-down disables the watchdog and clears its register.
// - Alarm or watchdog signalling overrides the test square wave.
// - Reset clears steer, multiplier, resolution, enables and test bit.
`timescale 1ns/10ps
module rtc_support
  import rtc_pkg::*;
#(
  parameter int RST_PULSE_CYCLES = RST_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [16:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  input wire logic osc_pin,
  input wire logic watchdog_kick_in,
  input wire logic on_battery,
  input wire logic battery_low,
  input wire time_now_s time_now,
  output logic sec_tick,
  output logic int_test_out,
  output logic int_test_oe_n,
  output logic reset_out,
  output logic reset_oe_n
);
  localparam int RW = $clog2(RST_PULSE_CYCLES + 1);
  localparam bus_pins_s BUS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                     kick: 1'b0, addr: 17'h00000,
                                     data: 8'h00};

  bus_pins_s bus_s;
  logic rd_d;
  logic wr_d;
  logic [16:0] addr_d;
  logic [16:0] waddr;
  logic [7:0] wdata;
  logic kick_d;
  logic bat_d;
  logic tick_d;
  logic sq512;
  logic tick16;
  logic [7:0] al_sec;
  logic [7:0] al_min;
  logic [7:0] al_hour;
  logic [7:0] al_date;
  logic [7:0] al_month;
  logic [7:0] wdog;
  logic [7:0] ctrl;
  logic [7:0] sec_reg;
  logic [7:0] day_reg;
  logic af;
  logic watchdog_expired_flag;
  logic af_irq;
  logic wd_irq;
  logic [10:0] wd_cnt;
  logic [RW-1:0] rst_cnt;

  // ---------------------------------------------------------------
  // Pin synchronisers and the divider chain
  // ---------------------------------------------------------------
  pin_sync #(.WIDTH($bits(bus_pins_s)), .RST_VAL(BUS_IDLE)) u_bus (
    .mclk(mclk),
    .rstn(rstn),
    .din({ce_n, we_n, oe_n, watchdog_kick_in, addr, dq_in}),
    .dout(bus_s)
  );

  osc_divider u_div (
    .mclk(mclk),
    .rstn(rstn),
    .osc_pin(osc_pin),
    .halt(sec_reg[BIT_ST]),
    .cal_sign(ctrl[BIT_SIGN]),
    .cal_mag(ctrl[CAL_HI:0]),
    .sec_tick(sec_tick),
    .sq512(sq512),
    .tick16(tick16)
  );

  // ---------------------------------------------------------------
  // Host bus decode
  // ---------------------------------------------------------------
  // A read is taken when it starts or when its address moves, so a
  // static read keeps showing the byte it first returned.
  wire rd_act = ~bus_s.ce_n & ~bus_s.oe_n & bus_s.we_n;
  wire wr_act = ~bus_s.ce_n & ~bus_s.we_n;
  wire rd_start = rd_act & (~rd_d | (bus_s.addr != addr_d));
  wire wr_end = wr_d & ~wr_act;
  wire hit_flags = bus_s.addr == ADDR_FLAGS;
  wire hit_asec = bus_s.addr == ADDR_AL_SEC;
  wire hit_amin = bus_s.addr == ADDR_AL_MIN;
  wire hit_ahour = bus_s.addr == ADDR_AL_HOUR;
  wire hit_adate = bus_s.addr == ADDR_AL_DATE;
  wire hit_amonth = bus_s.addr == ADDR_AL_MONTH;
  wire hit_wdog = bus_s.addr == ADDR_WDOG;
  wire hit_ctrl = bus_s.addr == ADDR_CTRL;
  wire hit_sec = bus_s.addr == ADDR_SEC;
  wire hit_day = bus_s.addr == ADDR_DAY;
  wire mapped = hit_flags | hit_asec | hit_amin | hit_ahour | hit_adate
                | hit_amonth | hit_wdog | hit_ctrl | hit_sec | hit_day;
  wire flags_rd = rd_start & hit_flags;
  wire wr_asec = wr_end & (waddr == ADDR_AL_SEC);
  wire wr_amin = wr_end & (waddr == ADDR_AL_MIN);
  wire wr_ahour = wr_end & (waddr == ADDR_AL_HOUR);
  wire wr_adate = wr_end & (waddr == ADDR_AL_DATE);
  wire wr_amonth = wr_end & (waddr == ADDR_AL_MONTH);
  wire wr_wdog = wr_end & (waddr == ADDR_WDOG);
  wire wr_ctrl = wr_end & (waddr == ADDR_CTRL);
  wire wr_sec = wr_end & (waddr == ADDR_SEC);
  wire wr_day = wr_end & (waddr == ADDR_DAY);

  // Read data selection; unused flag bits read as zero.
  wire [7:0] flags_byte = {watchdog_expired_flag, af, 1'b0, battery_low, 4'h0};
  wire [7:0] rdata = hit_flags ? flags_byte
                   : hit_asec ? al_sec
                   : hit_amin ? al_min
                   : hit_ahour ? al_hour
                   : hit_adate ? al_date
                   : hit_amonth ? al_month
                   : hit_wdog ? wdog
                   : hit_ctrl ? ctrl
                   : hit_sec ? sec_reg
                   : hit_day ? day_reg
                   : 8'h00;

  // ---------------------------------------------------------------
  // Power transitions
  // ---------------------------------------------------------------
  wire power_up = bat_d & ~on_battery;
  wire power_down = ~bat_d & on_battery;

  // ---------------------------------------------------------------
  // Alarm comparator
  // ---------------------------------------------------------------
  // Compared one cycle after sec_tick, once the counters have moved.
  wire [4:0] rpt = {al_date[BIT_RPT5], al_date[BIT_RPT], al_hour[BIT_RPT],
                    al_min[BIT_RPT], al_sec[BIT_RPT]};
  wire m_sec = time_now.sec[SEC_W-1:0] == al_sec[SEC_W-1:0];
  wire m_min = time_now.min[SEC_W-1:0] == al_min[SEC_W-1:0];
  wire m_hour = time_now.hour[HOUR_W-1:0] == al_hour[HOUR_W-1:0];
  wire m_date = time_now.date[DATE_W-1:0] == al_date[DATE_W-1:0];
  wire m_month = time_now.month[MONTH_W-1:0] == al_month[MONTH_W-1:0];
  wire alarm_hit = (rpt == RPT_MINUTE) ? m_sec
                 : (rpt == RPT_HOUR) ? m_sec & m_min
                 : (rpt == RPT_DAY) ? m_sec & m_min & m_hour
                 : (rpt == RPT_MONTH) ? m_sec & m_min & m_hour & m_date
                 : (rpt == RPT_YEAR) ? m_sec & m_min & m_hour & m_date
                                       & m_month
                 : 1'b1;
  wire alarm_event = tick_d & alarm_hit;
  // On battery the pin also needs the backup enable.
  wire alarm_pin = alarm_event & al_month[BIT_AFE]
                   & (~on_battery | al_month[BIT_ABE]);

  // ---------------------------------------------------------------
  // Watchdog decode
  // ---------------------------------------------------------------
  // The count runs in sixteenths of a second, so the limit is the
  // multiplier shifted left by twice the resolution code.
  wire [10:0] wd_limit = {6'h00, wdog[MULT_HI:MULT_LO]}
                         << {wdog[1:0], 1'b0};
  wire wd_en = wdog[MULT_HI:MULT_LO] != 5'h00;
  wire kick_edge = bus_s.kick ^ kick_d;
  wire restart = kick_edge | wr_wdog;
  wire timeout = wd_en & ~restart & tick16
                 & ((wd_cnt + 11'h001) == wd_limit);
  wire steer = wdog[BIT_WDS];
  wire wd_release = wr_wdog & (wdata == REG_RESET);
  wire rst_drive = rst_cnt != '0;

  // ---------------------------------------------------------------
  // Interrupt/test pin decode
  // ---------------------------------------------------------------
  // Any pending alarm or watchdog interrupt holds the pin low and
  // masks the square wave.
  wire irq_active = af_irq | wd_irq;
  wire ft_on = ~sec_reg[BIT_ST] & day_reg[BIT_FT] & ~al_month[BIT_AFE]
               & (steer | (wdog == REG_RESET));
  wire int_drive = irq_active | (ft_on & ~sq512);

  // ---------------------------------------------------------------
  // Bus front end and read data
  // ---------------------------------------------------------------
  // Write data is held while the strobe is low and used at its end.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_d <= 1'b0;
      wr_d <= 1'b0;
      addr_d <= 17'h00000;
      waddr <= 17'h00000;
      wdata <= 8'h00;
      kick_d <= 1'b0;
      bat_d <= 1'b0;
      tick_d <= 1'b0;
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
    end else begin
      rd_d <= rd_act;
      wr_d <= wr_act;
      addr_d <= bus_s.addr;
      kick_d <= bus_s.kick;
      bat_d <= on_battery;
      tick_d <= sec_tick;
      if (wr_act) begin
        waddr <= bus_s.addr;
        wdata <= bus_s.data;
      end
      if (rd_start) dq_out <= rdata;
      dq_oe_n <= ~(rd_act & mapped);
    end
  end

  // ---------------------------------------------------------------
  // Alarm and clock registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      al_sec <= REG_RESET;
      al_min <= REG_RESET;
      al_hour <= REG_RESET;
      al_date <= REG_RESET;
      al_month <= REG_RESET;
      ctrl <= REG_RESET;
      sec_reg <= REG_RESET;
    end else begin
      if (wr_asec) al_sec <= wdata;
      if (wr_amin) al_min <= wdata;
      if (wr_ahour) al_hour <= wdata;
      if (wr_adate) al_date <= wdata;
      if (wr_amonth) al_month <= wdata;
      if (wr_ctrl) ctrl <= wdata;
      if (wr_sec) sec_reg <= wdata;
      if (power_up) begin
        al_month[BIT_AFE] <= 1'b0;
        al_month[BIT_ABE] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Watchdog register, test bit and timeout counter
  // ---------------------------------------------------------------
  // The clears come after the host write so they take priority.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdog <= REG_RESET;
      day_reg <= REG_RESET;
      wd_cnt <= 11'h000;
    end else begin
      if (wr_wdog) wdog <= wdata;
      if (wr_day) day_reg <= wdata;
      if (timeout & steer) begin
        wdog <= REG_RESET;
        day_reg[BIT_FT] <= 1'b0;
      end
      if (power_down) wdog <= REG_RESET;
      if (!wd_en || restart || timeout) wd_cnt <= 11'h000;
      else if (tick16) wd_cnt <= wd_cnt + 11'h001;
    end
  end

  // ---------------------------------------------------------------
  // Flags and pending interrupts
  // ---------------------------------------------------------------
  // A set in the same cycle as the clearing read wins.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      af <= 1'b0;
      watchdog_expired_flag <= 1'b0;
      af_irq <= 1'b0;
      wd_irq <= 1'b0;
    end else begin
      af <= (af & ~flags_rd) | alarm_event;
      watchdog_expired_flag <= (watchdog_expired_flag & ~flags_rd) | timeout;
      af_irq <= (af_irq & ~flags_rd) | alarm_pin;
      wd_irq <= (wd_irq & ~wd_release) | (timeout & ~steer);
    end
  end

  // ---------------------------------------------------------------
  // Open-drain outputs
  // ---------------------------------------------------------------
  // Enables are low while a pin is pulled low; the reset pulse holds
  // for the parameter count, chosen at the short end of its window.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_cnt <= '0;
      reset_out <= 1'b1;
      reset_oe_n <= 1'b1;
      int_test_out <= 1'b1;
      int_test_oe_n <= 1'b1;
    end else begin
      if (timeout & steer) rst_cnt <= RW'(RST_PULSE_CYCLES);
      else if (rst_drive) rst_cnt <= rst_cnt - RW'(1);
      reset_out <= ~rst_drive;
      reset_oe_n <= ~rst_drive;
      int_test_out <= ~int_drive;
      int_test_oe_n <= ~int_drive;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_rst_low;
    ##2 (!reset_oe_n) [*8];
  endsequence

  a_alarm_sets: assert property (alarm_event |=> af)
    else $error("alarm match did not set the flag");
  a_flag_release: assert property (
    flags_rd && !alarm_event |=> !af && !af_irq)
    else $error("flags read did not release the alarm");
  a_repeat_sec: assert property (
    tick_d && rpt == 5'h1F |=> af)
    else $error("every-second alarm missed");
  a_backup_gate: assert property (
    alarm_event && on_battery && !al_month[BIT_ABE] && !af_irq
    |=> !af_irq)
    else $error("alarm drove the pin on battery without enable");
  a_wd_flag: assert property (timeout |=> watchdog_expired_flag)
    else $error("watchdog timeout did not set the flag");
  a_wd_reset: assert property (timeout && steer |-> s_rst_low)
    else $error("steered timeout gave no reset pulse");
  a_wd_clear: assert property (
    timeout && steer |=> wdog == 8'h00 && !day_reg[BIT_FT])
    else $error("steered timeout left watchdog or test bit set");
  a_kick_restart: assert property (
    kick_edge && wd_en |=> wd_cnt == 11'h000)
    else $error("kick edge did not restart the count");
  a_down_clear: assert property (power_down |=> wdog == 8'h00)
    else $error("power-down left the watchdog armed");
  a_irq_priority: assert property (
    irq_active |=> !int_test_oe_n && !int_test_out)
    else $error("pending interrupt did not hold the pin low");

endmodule : rtc_support

/* File: verif/host_bus_model.sv */
// Host processor model that drives the byte-wide register bus.
// Assumes the block needs three mclk cycles to see each strobe change.
`timescale 1ns/10ps
module host_bus_model (
  input wire logic mclk,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [16:0] addr,
  output logic [7:0] dq_in
);
  // The bus starts idle, with no strobe active.
  initial begin
    {ce_n, we_n, oe_n} = 3'h7;
    addr = 17'h00000;
    dq_in = 8'h00;
  end
  // One byte access is held four cycles and followed by an idle gap.
  // Released lines show inverted junk, so a stale value cannot pass.
  task automatic cyc(input logic [16:0] a, input logic [7:0] d,
                     input logic w, output logic [7:0] q, output logic z);
    @(posedge mclk);
    {ce_n, we_n, oe_n, addr, dq_in} <= {1'b0, ~w, w, a, d};
    repeat (4) @(posedge mclk);
    q = dq_out;
    z = dq_oe_n;
    {ce_n, we_n, oe_n, addr, dq_in} <= {3'h7, ~a, ~d};
    repeat (4) @(posedge mclk);
  endtask : cyc
endmodule : host_bus_model

/* File: verif/test_rtc_support.sv */
// Self-checking bench for the clock support block.
// Assumes a fast crystal (half of mclk) to keep the run short.
`timescale 1ns/10ps
module test_rtc_support;
  import rtc_pkg::*;
  logic mclk = 0, rstn = 0, osc_pin = 0, kick = 0, z, ce_n, we_n, oe_n;
  logic dq_oe_n, sec_tick, int_test_out, pin_n, reset_out, rst_n, bat = 0;
  logic [16:0] addr;
  logic [7:0] dq_in, dq_out, q;
  int err_total = 0, checked = 0, cyc_n = 0, n, tick_at = 0;
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) osc_pin <= ~osc_pin;
  // Cycle of the first second tick; the check accepts 65281 to 65299.
  always @(posedge mclk) if (sec_tick === 1'b1 && tick_at == 0) tick_at = cyc_n;
  rtc_support #(.RST_PULSE_CYCLES(20)) dut_u (.mclk(mclk), .rstn(rstn),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .osc_pin(osc_pin),
    .watchdog_kick_in(kick), .on_battery(bat), .battery_low(1'b1),
    .time_now('0), .sec_tick(sec_tick), .int_test_out(int_test_out),
    .int_test_oe_n(pin_n), .reset_out(reset_out), .reset_oe_n(rst_n));
  host_bus_model host_u (.mclk(mclk), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in));
  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    host_u.cyc(a, d, 1'b1, q, z);
  endtask : wr
  task automatic rd(input logic [16:0] a);
    host_u.cyc(a, 8'h00, 1'b0, q, z);
  endtask : rd
  // Counts settled cycles while a pin holds a level, up to a limit.
  task automatic hold(ref logic s, input logic v, input int lim);
    n = 0;
    while (s === v && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask : hold
  task automatic stop_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(ADDR_WDOG); chk(q, REG_RESET);
    rd(ADDR_AL_MONTH); chk(q, REG_RESET);
    rd(ADDR_DAY); chk(q, REG_RESET);
    rd(17'h1FFF1); chk({7'h00, z}, 8'h01);
    wr(ADDR_CTRL, 8'h3F); rd(ADDR_CTRL); chk(q, 8'h3F);
    wr(ADDR_FLAGS, 8'hFF); rd(ADDR_FLAGS); chk(q, 8'h10);
    $display("t_regs done");
  endtask : t_regs
  // The test wave keeps 64 mclk halves even with full calibration set.
  task automatic t_wdog_int;
    wr(ADDR_DAY, 8'h40); hold(pin_n, 1'b1, 300); hold(pin_n, 1'b0, 300);
    hold(pin_n, 1'b1, 300); hold(pin_n, 1'b0, 300);
    chk(8'(n), 8'd64);
    // Two units of 1/16 s: the free tick lands 4096 to 8192 cycles on.
    wr(ADDR_WDOG, 8'h08); hold(pin_n, 1'b1, 300);
    chk({7'h00, n == 300}, 8'h01);
    wr(ADDR_DAY, 8'h00); hold(pin_n, 1'b1, 9000);
    chk({7'h00, n + 308 > 4096 && n + 308 < 8200}, 8'h01);
    rd(ADDR_FLAGS); chk(q, 8'h90);
    rd(ADDR_FLAGS); chk(q, 8'h10);
    chk({6'h00, int_test_out, pin_n}, 8'h00);
    wr(ADDR_WDOG, 8'h00); @(negedge mclk);
    chk({6'h00, int_test_out, pin_n}, 8'h03);
    $display("t_wdog_int done");
  endtask : t_wdog_int
  // Pin edges and register writes both restart the count in time.
  // A two-unit limit is beaten by 3000-cycle kicks at any tick phase.
  task automatic t_kick;
    wr(ADDR_WDOG, 8'h08);
    repeat (4) begin
      repeat (3000) @(posedge mclk);
      kick <= ~kick;
    end
    chk({7'h00, pin_n}, 8'h01);
    repeat (3000) @(posedge mclk);
    wr(ADDR_WDOG, 8'h08); repeat (3000) @(posedge mclk);
    chk({7'h00, pin_n}, 8'h01);
    wr(ADDR_WDOG, 8'h84); hold(rst_n, 1'b1, 5000);
    chk({6'h00, reset_out, rst_n}, 8'h00);
    hold(rst_n, 1'b0, 99);
    chk(8'(n), 8'd20);
    rd(ADDR_WDOG); chk(q, 8'h00);
    rd(ADDR_FLAGS); chk(q, 8'h90);
    $display("t_kick done");
  endtask : t_kick
  // Power-down clears the watchdog; power-up clears both alarm enables.
  task automatic t_power;
    wr(ADDR_WDOG, 8'h08); wr(ADDR_AL_MONTH, 8'hA0);
    bat <= 1'b1; rd(ADDR_WDOG); chk(q, REG_RESET);
    bat <= 1'b0; rd(ADDR_AL_MONTH); chk(q, REG_RESET);
    $display("t_power done");
  endtask : t_power
  task automatic t_alarm;
    wr(ADDR_AL_SEC, 8'h80); wr(ADDR_AL_MIN, 8'h80); wr(ADDR_AL_HOUR, 8'h80);
    wr(ADDR_AL_DATE, 8'hC0); wr(ADDR_AL_MONTH, 8'h80);
    hold(pin_n, 1'b1, 70000); chk({7'h00, n < 70000}, 8'h01);
    // Full positive calibration makes the first second 128 crystal
    // cycles (256 mclk) short of 65536 mclk.
    chk({7'h00, tick_at > 65280 && tick_at < 65300}, 8'h01);
    rd(ADDR_FLAGS); chk(q, 8'h50);
    chk({7'h00, pin_n}, 8'h01);
    wr(ADDR_AL_DATE, 8'h00); wr(ADDR_AL_SEC, 8'h00);
    wr(ADDR_AL_MIN, 8'h00); wr(ADDR_AL_HOUR, 8'h00);
    rd(ADDR_FLAGS); chk(q, 8'h10);
    $display("t_alarm done");
  endtask : t_alarm
  // The run is cut short if a wait never ends.
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 80000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_regs(); t_wdog_int(); t_kick(); t_power(); t_alarm();
    stop_test();
  end
endmodule : test_rtc_support
